//--- bench/hot_swap_status_summary_regs_tb.sv
// Purpose: Self-checking bench for the status summary registers
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Waits of 3 edges cover flag plus summary latency
`timescale 1ns/1ps
module hot_swap_status_summary_regs_tb;
   logic                 clk_sys, rst_n, power_good, hotswap_off, comm_fault, oc_warn;
   hsss_pkg::hsss_cond_t cond;
   hsss_pkg::hsss_clr_t  clr;
   logic [11:0]          vin_code, uv_limit;
   logic [7:0]           vendor, rd_addr, status_byte;
   logic [15:0]          rd_data, summary;
   int                   failures, checked, cycles;

   hsss_regs dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .COND(cond), .OC_WARN_EXCEEDED(oc_warn),
      .VIN_CODE(vin_code), .UV_WARN_LIMIT(uv_limit), .POWER_GOOD_PIN(power_good),
      .HOTSWAP_OFF(hotswap_off), .COMM_FAULT(comm_fault), .VENDOR_STATUS(vendor),
      .CLR(clr), .RD_ADDR(rd_addr), .RD_DATA(rd_data), .SUMMARY_WORD(summary),
      .STATUS_BYTE(status_byte));
   hsss_host_model host (.CLK_SYS(clk_sys), .RD_DATA(rd_data), .RD_ADDR(rd_addr), .CLR(clr));

   // ------------------------------------------------------------
   // Clock, timeout and shared tasks
   // ------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // Ceiling well above the 125 or so cycles the tests need
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         results();
      end
   end

   task automatic wait_edges(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : wait_edges

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic results;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : results

   // Drive one cause; index follows the expectation tables below
   task automatic set_cause(input int i, input logic v);
      case (i)
         0: cond.oc_timeout = v;
         1: oc_warn = v;
         2: cond.ov_pin = v;
         3: cond.input_overvoltage_warning = v;
         4: vin_code = v ? 12'h7ff : 12'h800; // Idle equals limit: strict compare holds off
         5: cond.uv_pin = v;
         default: cond.input_overpower_warning = v;
      endcase
   endtask : set_cause

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Every register and an unmapped code read zero after reset
   task automatic reset_values;
      logic [7:0]  addr [6] = '{8'h78, 8'h79, 8'h7b, 8'h7c, 8'h80, 8'h7a};
      logic [15:0] d;
      foreach (addr[k]) begin
         host.read_reg(addr[k], d);
         check("reset read", d, 16'h0000);
      end
   endtask : reset_values

   // Live bits follow their sources both ways
   task automatic live_flags;
      logic [15:0] d;
      power_good = 1'b0;
      wait_edges(3);
      check("power bad", summary, 16'h0800);
      host.read_reg(hsss_pkg::SUMMARY_WORD_ADDR, d);
      check("word read", d, 16'h0800);
      power_good  = 1'b1;
      vendor      = 8'h01;
      hotswap_off = 1'b1;
      comm_fault  = 1'b1;
      wait_edges(3);
      check("vendor", summary, 16'h1043);
      host.read_reg(hsss_pkg::STATUS_BYTE_ADDR, d);
      check("byte read", d, 16'h0043);
      host.read_reg(hsss_pkg::VENDOR_STAT_ADDR, d);
      check("vendor read", d, 16'h0001);
      vendor      = 8'h00;
      hotswap_off = 1'b0;
      comm_fault  = 1'b0;
      wait_edges(3);
      check("live drop", summary, 16'h0000);
   endtask : live_flags

   // Each latched flag outlasts a one-cycle cause, then clears
   task automatic latched_flags;
      logic [7:0]  det [7] = '{8'h80, 8'h20, 8'h80, 8'h40, 8'h20, 8'h10, 8'h01};
      logic [15:0] sw  [7] = '{16'h4011, 16'h4001, 16'h2001, 16'h2001, 16'h2001, 16'h2009,
                               16'h2001};
      logic [15:0] d;
      for (int i = 0; i < 7; i++) begin
         set_cause(i, 1'b1);
         wait_edges(1);
         set_cause(i, 1'b0);
         wait_edges(3);
         host.read_reg(i < 2 ? hsss_pkg::OUTPUT_STAT_ADDR : hsss_pkg::INPUT_STAT_ADDR, d);
         check("detail", d, {8'h00, det[i]});
         check("summary", summary, sw[i]);
         check("byte", {8'h00, status_byte}, {8'h00, sw[i][7:0]});
         host.clear(i < 2 ? 8'hff : 8'h00, i < 2 ? 8'h00 : 8'hff);
         wait_edges(3);
         check("cleared", summary, 16'h0000);
      end
   endtask : latched_flags

   // Equal code does not set; a set beats a clear in the same cycle
   task automatic set_wins;
      logic [15:0] d;
      uv_limit = 12'h100;
      vin_code = 12'h100;
      wait_edges(3);
      host.read_reg(hsss_pkg::INPUT_STAT_ADDR, d);
      check("uv equal", d, 16'h0000);
      vin_code = 12'h0ff;
      host.clear(8'h00, 8'hff);
      vin_code = 12'h800;
      uv_limit = 12'h800;
      host.read_reg(hsss_pkg::INPUT_STAT_ADDR, d);
      check("set wins", d, 16'h0020);
      host.clear(8'h00, 8'hff);
      wait_edges(3);
      check("uv cleared", summary, 16'h0000);
   endtask : set_wins

   // Reset for 4 cycles, then the first request after the 8th edge
   initial begin
      rst_n       = 1'b0;
      cond        = '0;
      oc_warn     = 1'b0;
      vin_code    = 12'h800;
      uv_limit    = 12'h800;
      power_good  = 1'b1;
      hotswap_off = 1'b0;
      comm_fault  = 1'b0;
      vendor      = 8'h00;
      repeat (4) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      wait_edges(3);
      reset_values();
      live_flags();
      latched_flags();
      set_wins();
      results();
   end
endmodule : hot_swap_status_summary_regs_tb

//--- bench/hsss_host_model.sv
// Purpose: Host-side model that reads status registers and pulses clears
// Assumes: Requests change 1 ns after a rising edge; read data one cycle later
// Notes:   Address parks on an unmapped code between reads
`timescale 1ns/1ps
module hsss_host_model (
   // Clock
   input  wire logic          CLK_SYS,
   // Device read and clear port
   input  wire logic [15:0]   RD_DATA,
   output logic      [7:0]    RD_ADDR,
   output hsss_pkg::hsss_clr_t CLR
);
   // ------------------------------------------------------------
   // Host requests
   // ------------------------------------------------------------
   // Idle on an unmapped code so a stale address never reads a register
   initial begin
      RD_ADDR = 8'hff;
      CLR     = '0;
   end

   // Code held over one edge, answer taken once the next edge settles
   task automatic read_reg(input logic [7:0] addr, output logic [15:0] data);
      @(posedge CLK_SYS);
      #1 RD_ADDR = addr;
      @(posedge CLK_SYS);
      #1 data = RD_DATA;
      RD_ADDR = 8'hff;
   endtask : read_reg

   // One-cycle clear pulse per bit
   task automatic clear(input logic [7:0] out_mask, input logic [7:0] in_mask);
      @(posedge CLK_SYS);
      #1 CLR = '{output_clr: out_mask, input_clr: in_mask};
      @(posedge CLK_SYS);
      #1 CLR = '0;
   endtask : clear
endmodule : hsss_host_model

//--- hdl/hsss_regs.sv
// Purpose: Summary status word and output and input detail status registers
// Assumes: Inputs synchronous to CLK_SYS; host clears latched bits by mask
// Notes:   Read data is registered, one cycle after the address
`timescale 1ns/1ps
module hsss_regs (
   // Clock and reset
   input  wire logic                    CLK_SYS,
   input  wire logic                    RST_N,
   // Conditions
   input  wire hsss_pkg::hsss_cond_t    COND,
   input  wire logic                    OC_WARN_EXCEEDED,
   input  wire logic [11:0]             VIN_CODE,
   input  wire logic [11:0]             UV_WARN_LIMIT,
   input  wire logic                    POWER_GOOD_PIN,
   input  wire logic                    HOTSWAP_OFF,
   input  wire logic                    COMM_FAULT,
   input  wire logic [7:0]              VENDOR_STATUS,
   // Clears
   input  wire hsss_pkg::hsss_clr_t     CLR,
   // Read port
   input  wire logic [7:0]              RD_ADDR,
   output logic [15:0]                  RD_DATA,
   output logic [15:0]                  SUMMARY_WORD,
   output logic [7:0]                   STATUS_BYTE
);
   logic       rst_meta;
   logic       rst_sync_n;
   logic [7:0] output_current_status;
   logic [7:0] input_condition_status;
   logic [7:0] next_output;
   logic [7:0] next_input;
   logic [7:0] output_set;
   logic [7:0] input_set;
   logic [7:0] status_byte_live;
   logic [15:0] summary_live;
   logic [15:0] next_rd;
   logic        uv_warn_cmp;
   logic        output_summary_flag;
   logic        input_summary_flag;
   logic        vendor_summary_flag;
   logic        power_bad_flag;

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   // Two stage release keeps deassertion clean against the clock
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta   <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta   <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   // ------------------------------------------------------------
   // Latched flag sources
   // ------------------------------------------------------------
   // Threshold compare, strictly below the limit
   assign uv_warn_cmp = VIN_CODE < UV_WARN_LIMIT;
   // Set terms; reserved positions never set
   assign output_set = {COND.oc_timeout, 1'b0, OC_WARN_EXCEEDED, 5'h00};
   assign input_set  = {COND.ov_pin, COND.input_overvoltage_warning, uv_warn_cmp,
                        COND.uv_pin, 3'h0, COND.input_overpower_warning};
   // Set wins over a clear in the same cycle
   assign next_output = output_set | (output_current_status & ~CLR.output_clr);
   assign next_input  = input_set | (input_condition_status & ~CLR.input_clr);

   always_ff @(posedge CLK_SYS or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         output_current_status  <= hsss_pkg::BYTE_RESET;
         input_condition_status <= hsss_pkg::BYTE_RESET;
      end else begin
         output_current_status  <= next_output;
         input_condition_status <= next_input;
      end
   end

   // ------------------------------------------------------------
   // Live summary flags
   // ------------------------------------------------------------
   assign output_summary_flag = |output_current_status;
   assign input_summary_flag  = |input_condition_status;
   assign vendor_summary_flag = |VENDOR_STATUS;
   assign power_bad_flag      = ~POWER_GOOD_PIN;
   // Other pending covers every output, input and vendor detail bit, including those shown in the byte
   assign status_byte_live = {1'b0, HOTSWAP_OFF, 1'b0,
                              output_current_status[hsss_pkg::OUT_OCF_BIT],
                              input_condition_status[hsss_pkg::IN_UVF_BIT], 1'b0,
                              COMM_FAULT,
                              output_summary_flag | input_summary_flag
                              | vendor_summary_flag};
   assign summary_live = {1'b0, output_summary_flag, input_summary_flag,
                          vendor_summary_flag, power_bad_flag, 3'h0,
                          status_byte_live};

   // ------------------------------------------------------------
   // Read decode
   // ------------------------------------------------------------
   // Unmapped codes read zero
   assign next_rd = (RD_ADDR == hsss_pkg::SUMMARY_WORD_ADDR) ? summary_live :
                    (RD_ADDR == hsss_pkg::STATUS_BYTE_ADDR)  ? {8'h00, status_byte_live} :
                    (RD_ADDR == hsss_pkg::OUTPUT_STAT_ADDR)  ? {8'h00, output_current_status} :
                    (RD_ADDR == hsss_pkg::INPUT_STAT_ADDR)   ? {8'h00, input_condition_status} :
                    (RD_ADDR == hsss_pkg::VENDOR_STAT_ADDR)  ? {8'h00, VENDOR_STATUS} :
                    16'h0000;

   // Registered outputs; summary and byte snapshots taken together
   always_ff @(posedge CLK_SYS or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         RD_DATA      <= hsss_pkg::SUMMARY_RESET;
         SUMMARY_WORD <= hsss_pkg::SUMMARY_RESET;
         STATUS_BYTE  <= hsss_pkg::BYTE_RESET;
      end else begin
         RD_DATA      <= next_rd;
         SUMMARY_WORD <= summary_live;
         STATUS_BYTE  <= status_byte_live;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_bit15_zero;
      @(posedge CLK_SYS) disable iff (!rst_sync_n) SUMMARY_WORD[15] == 1'b0;
   endproperty
   a_bit15_zero: assert property (p_bit15_zero) else $error("bit15 set");

   property p_out_summary;
      @(posedge CLK_SYS) disable iff (!rst_sync_n)
         ##1 SUMMARY_WORD[14] == (|$past(output_current_status));
   endproperty
   a_out_summary: assert property (p_out_summary) else $error("bit14 wrong");

   property p_in_summary;
      @(posedge CLK_SYS) disable iff (!rst_sync_n)
         ##1 SUMMARY_WORD[13] == (|$past(input_condition_status));
   endproperty
   a_in_summary: assert property (p_in_summary) else $error("bit13 wrong");

   property p_vendor_summary;
      @(posedge CLK_SYS) disable iff (!rst_sync_n)
         ##1 SUMMARY_WORD[12] == (|$past(VENDOR_STATUS));
   endproperty
   a_vendor_summary: assert property (p_vendor_summary) else $error("bit12 wrong");

   property p_pbad;
      @(posedge CLK_SYS) disable iff (!rst_sync_n)
         ##1 SUMMARY_WORD[11] == !$past(POWER_GOOD_PIN);
   endproperty
   a_pbad: assert property (p_pbad) else $error("bit11 wrong");

   property p_reserved;
      @(posedge CLK_SYS) disable iff (!rst_sync_n)
         SUMMARY_WORD[10:8] == 3'h0 && output_current_status[6] == 1'b0
         && output_current_status[4:0] == 5'h00 && input_condition_status[3:1] == 3'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved set");

   property p_byte_match;
      @(posedge CLK_SYS) disable iff (!rst_sync_n) SUMMARY_WORD[7:0] == STATUS_BYTE;
   endproperty
   a_byte_match: assert property (p_byte_match) else $error("byte mismatch");

   property p_ocf_latch;
      @(posedge CLK_SYS) disable iff (!rst_sync_n)
         COND.oc_timeout |=> output_current_status[hsss_pkg::OUT_OCF_BIT];
   endproperty
   a_ocf_latch: assert property (p_ocf_latch) else $error("oc fault lost");

   property p_ocw_latch;
      @(posedge CLK_SYS) disable iff (!rst_sync_n)
         OC_WARN_EXCEEDED |=> output_current_status[hsss_pkg::OUT_OCW_BIT];
   endproperty
   a_ocw_latch: assert property (p_ocw_latch) else $error("oc warn lost");

   property p_ovf_latch;
      @(posedge CLK_SYS) disable iff (!rst_sync_n)
         COND.ov_pin |=> input_condition_status[hsss_pkg::IN_OVF_BIT];
   endproperty
   a_ovf_latch: assert property (p_ovf_latch) else $error("ov fault lost");

   property p_ovw_latch;
      @(posedge CLK_SYS) disable iff (!rst_sync_n)
         COND.input_overvoltage_warning |=> input_condition_status[hsss_pkg::IN_OVW_BIT];
   endproperty
   a_ovw_latch: assert property (p_ovw_latch) else $error("ov warn lost");

   property p_uvw_latch;
      @(posedge CLK_SYS) disable iff (!rst_sync_n)
         (VIN_CODE < UV_WARN_LIMIT) |=> input_condition_status[hsss_pkg::IN_UVW_BIT];
   endproperty
   a_uvw_latch: assert property (p_uvw_latch) else $error("uv warn lost");

   property p_uvf_latch;
      @(posedge CLK_SYS) disable iff (!rst_sync_n)
         COND.uv_pin |=> input_condition_status[hsss_pkg::IN_UVF_BIT];
   endproperty
   a_uvf_latch: assert property (p_uvf_latch) else $error("uv fault lost");

   property p_opw_latch;
      @(posedge CLK_SYS) disable iff (!rst_sync_n)
         COND.input_overpower_warning |=> input_condition_status[hsss_pkg::IN_OPW_BIT];
   endproperty
   a_opw_latch: assert property (p_opw_latch) else $error("op warn lost");

   property p_other;
      @(posedge CLK_SYS) disable iff (!rst_sync_n)
         ##1 STATUS_BYTE[0] == (|$past(output_current_status) || |$past(input_condition_status)
                                || |$past(VENDOR_STATUS));
   endproperty
   a_other: assert property (p_other) else $error("other pending wrong");

   property p_hold;
      @(posedge CLK_SYS) disable iff (!rst_sync_n)
         (output_current_status[7] && !CLR.output_clr[7]) |=> output_current_status[7];
   endproperty
   a_hold: assert property (p_hold) else $error("latched flag dropped");

   // No input bit may fall unless its clear strobe was high
   property p_hold_in;
      @(posedge CLK_SYS) disable iff (!rst_sync_n)
         ##1 ((($past(input_condition_status) & ~$past(CLR.input_clr))
               & ~input_condition_status) == 8'h00);
   endproperty
   a_hold_in: assert property (p_hold_in) else $error("latched input flag dropped");
endmodule : hsss_regs

//--- include/hsss_pkg.sv
// Purpose: Constants and carriers for the hot swap status summary registers
// Assumes: Register access by command code, reads only, clears by strobe
// Notes:   Offsets are command codes; widths are fixed
package hsss_pkg;
   // ------------------------------------------------------------
   // Register command codes
   // ------------------------------------------------------------
   localparam logic [7:0]  STATUS_BYTE_ADDR   = 8'h78;
   localparam logic [7:0]  SUMMARY_WORD_ADDR  = 8'h79;
   localparam logic [7:0]  OUTPUT_STAT_ADDR   = 8'h7b;
   localparam logic [7:0]  INPUT_STAT_ADDR    = 8'h7c;
   localparam logic [7:0]  VENDOR_STAT_ADDR   = 8'h80;
   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [15:0] SUMMARY_RESET      = 16'h0000;
   localparam logic [7:0]  BYTE_RESET         = 8'h00;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int SW_OUTPUT_BIT   = 14;
   localparam int SW_INPUT_BIT    = 13;
   localparam int SW_VENDOR_BIT   = 12;
   localparam int SW_PBAD_BIT     = 11;
   localparam int OUT_OCF_BIT     = 7;
   localparam int OUT_OCW_BIT     = 5;
   localparam int IN_OVF_BIT      = 7;
   localparam int IN_OVW_BIT      = 6;
   localparam int IN_UVW_BIT      = 5;
   localparam int IN_UVF_BIT      = 4;
   localparam int IN_OPW_BIT      = 0;
   localparam int SB_OCF_BIT      = 4;
   localparam int SB_UVF_BIT      = 3;
   localparam int SB_OTHER_BIT    = 0;
   localparam int LIMIT_W         = 12;

   // Raw condition inputs from comparators and the power monitor
   typedef struct packed {
      logic oc_timeout;   // Overcurrent outlasted fault timer, gate off
      logic ov_pin;       // Overvoltage comparator
      logic uv_pin;       // Undervoltage comparator
      logic input_overvoltage_warning;  // Monitor over warning threshold
      logic input_overpower_warning;  // Monitor over power threshold
   } hsss_cond_t;

   // Flag clear strobes from the host side
   typedef struct packed {
      logic [7:0] output_clr;
      logic [7:0] input_clr;
   } hsss_clr_t;
endpackage : hsss_pkg
